// file: rtl/tone_ring_buzzer_remote_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module tone_ring_buzzer_remote_ctl #(
  parameter int DEBOUNCE_CYCLES = ctl_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               cclk,
  input  wire logic               cs_b,
  input  wire logic               ci,
  output logic                    co,
  output logic                    co_oe,
  input  wire logic               key_sense_in,
  input  wire logic               power_down,
  output logic                    key_state_out,
  output logic                    buzzer_out,
  output logic signed [7:0]       tone_sample,
  output ctl_pkg::analog_type     analog_ctl,
  output logic [7:0]              uplink_override
);
  // ---------------- serial port, cclk domain ----------------
  logic        ser_rst_b;
  logic [4:0]  bit_cnt_q;
  logic [4:0]  bit_cnt_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic        cmd_done;
  logic        frame_done;
  logic [3:0]  rd_addr_q;
  logic        rd_mode_q;
  logic        rd_tog_q;
  logic        wr_tog_q;
  logic [15:0] frame_q;
  logic        co_q;
  logic [6:0]  out_sh_q;
  logic [7:0]  rd_word_q;

  // cs_b high ends a frame even if cclk has stopped
  assign ser_rst_b  = rst_b & ~cs_b;
  assign cmd_done   = (bit_cnt_q == ctl_pkg::CMD_LAST_BIT);
  assign frame_done = (bit_cnt_q == ctl_pkg::FRAME_LAST);
  assign shift_d    = {shift_q[14:0], ci};
  assign bit_cnt_d  = (bit_cnt_q == ctl_pkg::FRAME_BITS) ? bit_cnt_q : bit_cnt_q + 5'h01;

  always_ff @(posedge cclk or negedge ser_rst_b) begin
    if (!ser_rst_b) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 16'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
    end
  end

  always_ff @(posedge cclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_addr_q <= 4'h0;
      rd_mode_q <= 1'b0;
      rd_tog_q  <= 1'b0;
      wr_tog_q  <= 1'b0;
      frame_q   <= 16'h0000;
    end else begin
      if (cmd_done) begin
        rd_addr_q <= shift_d[3:0];
        rd_mode_q <= shift_d[ctl_pkg::CMD_READ_BIT];
        if (shift_d[ctl_pkg::CMD_READ_BIT]) begin
          rd_tog_q <= ~rd_tog_q;
        end
      end
      if (frame_done && !rd_mode_q) begin
        frame_q  <= shift_d;
        wr_tog_q <= ~wr_tog_q;
      end
    end
  end

  // read word is loaded half a cclk after the request toggle; it has settled
  always_ff @(negedge cclk or negedge ser_rst_b) begin
    if (!ser_rst_b) begin
      co_q     <= 1'b0;
      out_sh_q <= 7'h00;
    end else if (bit_cnt_q == ctl_pkg::DATA_FIRST) begin
      co_q     <= rd_word_q[7];
      out_sh_q <= rd_word_q[6:0];
    end else begin
      co_q     <= out_sh_q[6];
      out_sh_q <= {out_sh_q[5:0], 1'b0};
    end
  end

  assign co    = co_q;
  // enable rises on the last command rising edge, half a cclk before the first data bit leaves on the following falling edge
  assign co_oe = rd_mode_q & ~cs_b & (bit_cnt_q >= ctl_pkg::DATA_FIRST);

  // ---------------- crossings into sys_clk ----------------
  logic [2:0] wr_sync_q;
  logic [2:0] rd_sync_q;
  logic [1:0] key_sync_q;
  logic [1:0] pd_sync_q;
  logic       wr_evt;
  logic       rd_evt;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_sync_q  <= 3'h0;
      rd_sync_q  <= 3'h0;
      key_sync_q <= 2'h3;
      pd_sync_q  <= 2'h0;
    end else begin
      wr_sync_q  <= {wr_sync_q[1:0], wr_tog_q};
      rd_sync_q  <= {rd_sync_q[1:0], rd_tog_q};
      key_sync_q <= {key_sync_q[0], key_sense_in};
      pd_sync_q  <= {pd_sync_q[0], power_down};
    end
  end

  assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
  assign rd_evt = rd_sync_q[2] ^ rd_sync_q[1];

  // ---------------- register file ----------------
  logic [7:0] ctl_q [16];
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_remote;

  assign wr_addr   = frame_q[11:8];
  assign wr_data   = frame_q[7:0];
  assign wr_remote = wr_evt && (wr_addr == ctl_pkg::IDX_REMOTE);

  for (genvar i = 0; i < 16; i++) begin : g_reg
    if (i >= int'(ctl_pkg::IDX_UPLINK) && i <= int'(ctl_pkg::IDX_BUZZER)) begin : g_map
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          ctl_q[i] <= ctl_pkg::RESET_BYTE;
        end else if (wr_evt && wr_addr == 4'(i)) begin
          ctl_q[i] <= wr_data;
        end
      end
    end else begin : g_gap
      assign ctl_q[i] = 8'h00;
    end
  end

  ctl_pkg::path_type   path;
  ctl_pkg::tone_type   tone;
  ctl_pkg::remote_type rem;
  ctl_pkg::buzzer_type bz;
  logic [7:0]          gain_tx;
  logic [7:0]          gain_rx;

  assign path    = ctl_pkg::path_type'(ctl_q[ctl_pkg::IDX_PATH]);
  assign tone    = ctl_pkg::tone_type'(ctl_q[ctl_pkg::IDX_TONE]);
  assign rem     = ctl_pkg::remote_type'(ctl_q[ctl_pkg::IDX_REMOTE]);
  assign bz      = ctl_pkg::buzzer_type'(ctl_q[ctl_pkg::IDX_BUZZER]);
  assign gain_tx = ctl_q[ctl_pkg::IDX_TXGAIN];
  assign gain_rx = ctl_q[ctl_pkg::IDX_RXGAIN];
  assign uplink_override = ctl_q[ctl_pkg::IDX_UPLINK];

  // ---------------- remote key detection ----------------
  logic        det_flag_q;
  logic        pressed_q;
  logic [22:0] deb_cnt_q;
  logic        key_low;
  logic        deb_hit;
  logic        key_view;
  logic        key_out_q;

  assign key_low = ~key_sync_q[1];
  assign deb_hit = (deb_cnt_q == 23'(DEBOUNCE_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      deb_cnt_q <= 23'h000000;
      pressed_q <= 1'b0;
    end else if (key_low == pressed_q) begin
      deb_cnt_q <= 23'h000000;
    end else if (deb_hit) begin
      deb_cnt_q <= 23'h000000;
      pressed_q <= key_low;
    end else begin
      deb_cnt_q <= deb_cnt_q + 23'h000001;
    end
  end

  // set wins over the clearing write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      det_flag_q <= 1'b0;
    end else if (rem.remote_enable && pressed_q) begin
      det_flag_q <= 1'b1;
    end else if (wr_remote) begin
      det_flag_q <= 1'b0;
    end
  end

  assign key_view = rem.remote_latch_mode ? det_flag_q : pressed_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_out_q <= 1'b0;
    end else begin
      key_out_q <= (rem.remote_enable & key_view) ^ rem.remote_out_invert;
    end
  end

  assign key_state_out = key_out_q;

  // ---------------- read-back ----------------
  logic [7:0] rem_view;
  logic [7:0] rd_sel;

  assign rem_view = {ctl_q[ctl_pkg::IDX_REMOTE][7:5], det_flag_q, ctl_q[ctl_pkg::IDX_REMOTE][3:0]};
  assign rd_sel   = (rd_addr_q == ctl_pkg::IDX_UPLINK) ? 8'h00 :
                    (rd_addr_q == ctl_pkg::IDX_REMOTE) ? rem_view : ctl_q[rd_addr_q];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_word_q <= 8'h00;
    end else if (rd_evt) begin
      rd_word_q <= rd_sel;
    end
  end

  // ---------------- tone generators ----------------
  logic [13:0] tick_acc_q;
  logic [13:0] tick_sum;
  logic        tick;
  logic [1:0]  range;
  logic [ctl_pkg::PHASE_W-1:0] phase_q [2];
  logic [ctl_pkg::PHASE_W-1:0] inc     [2];
  logic signed [7:0]           wave    [2];

  assign tick_sum = tick_acc_q + ctl_pkg::TICK_STEP;
  assign tick     = (tick_sum >= ctl_pkg::TICK_MOD);
  // forbidden code 11 falls back to the standard range
  assign range    = {rem.range_double_sel, rem.range_half_sel};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_acc_q <= 14'h0000;
    end else begin
      tick_acc_q <= tick ? tick_sum - ctl_pkg::TICK_MOD : tick_sum;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_tone
    logic [7:0] n;
    logic [1:0] quad;
    logic [3:0] idx;
    logic [6:0] mag;
    logic signed [7:0] sine;

    assign n = ctl_q[g == 0 ? ctl_pkg::IDX_FREQ_A : ctl_pkg::IDX_FREQ_B];
    // phase step of n*7.8125 Hz per unit in the standard range (half 3.90625, double 15.625) at the 512 kHz tick
    assign inc[g] = (range == ctl_pkg::RANGE_HALF)   ? {9'h000, n} :
                    (range == ctl_pkg::RANGE_DOUBLE) ? {7'h00, n, 2'h0} :
                    {8'h00, n, 1'h0};
    assign quad = phase_q[g][16:15];
    assign idx  = quad[0] ? ~phase_q[g][14:11] : phase_q[g][14:11];
    assign mag  = ctl_pkg::SINE_QTR[idx];
    assign sine = quad[1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    assign wave[g] = tone.sine_square_sel ? sine :
                     (phase_q[g][16] ? -ctl_pkg::WAVE_PEAK : ctl_pkg::WAVE_PEAK);

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        phase_q[g] <= '0;
      end else if (tick) begin
        phase_q[g] <= phase_q[g] + inc[g];
      end
    end
  end

  logic signed [13:0] b_prod;
  logic signed [7:0]  b_scaled;
  logic signed [7:0]  tone_d;
  logic signed [7:0]  tone_q;

  // 51/64 is about 2 dB down
  assign b_prod   = 14'(wave[1]) * ctl_pkg::TONE_B_SCALE;
  assign b_scaled = b_prod[13:6];
  assign tone_d   = (tone.tone_a_sel && tone.tone_b_sel) ? wave[0] + b_scaled :
                    tone.tone_a_sel ? wave[0] :
                    tone.tone_b_sel ? b_scaled : 8'sh00;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tone_q <= 8'sh00;
    end else begin
      tone_q <= tone_d;
    end
  end

  assign tone_sample = tone_q;

  // ---------------- buzzer ----------------
  logic [6:0] slice;
  logic       slice_on;
  logic       b_gate;
  logic       bz_run;
  logic       bz_q;

  assign slice    = phase_q[0][16:10];
  assign slice_on = (slice < {1'b0, bz.duty});
  assign b_gate   = ~tone.tone_b_sel | ~phase_q[1][16];
  assign bz_run   = bz.buzzer_enable & ~pd_sync_q[1];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bz_q <= 1'b0;
    end else begin
      bz_q <= (bz_run & slice_on & b_gate) ^ bz.buzzer_polarity;
    end
  end

  assign buzzer_out = bz_q;

  // ---------------- analog selects ----------------
  ctl_pkg::tx_input_type tx_in;
  ctl_pkg::analog_type   an_d;
  ctl_pkg::analog_type   an_q;

  assign tx_in = ctl_pkg::tx_input_type'({path.tx_input_sel_hi, path.tx_input_sel_lo});
  assign an_d = '{
    tx_input:        tx_in,
    tx_gain:         gain_tx[7:4],
    sidetone_on:     path.sidetone_en && (tx_in != ctl_pkg::TX_MUTE),
    sidetone_atten:  gain_tx[3:0],
    earpiece_on:     path.earpiece_out_sel & ~path.extra_out_sel,
    extra_on:        path.extra_out_sel & ~path.earpiece_out_sel,
    tone_to_extra:   path.tone_route_sel,
    speech_to_extra: path.rx_speech_route,
    rx_hpf_sel:      path.rx_hpf_sel,
    earpiece_gain:   gain_rx[7:4],
    extra_gain:      gain_rx[3:0],
    tone_atten:      tone.tone_atten,
    tone_to_uplink:  tone.tone_to_uplink,
    preamp_0db:      rem.preamp_gain_sel,
    mic_bias_on:     rem.mic_bias_on
  };

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      an_q <= '0;
    end else begin
      an_q <= an_d;
    end
  end

  assign analog_ctl = an_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_sidetone_gate;
    an_q.sidetone_on |-> an_q.tx_input != ctl_pkg::TX_MUTE;
  endproperty
  a_sidetone_gate: assert property (p_sidetone_gate) else $error("sidetone on while muted");

  property p_out_excl;
    !(an_q.earpiece_on && an_q.extra_on);
  endproperty
  a_out_excl: assert property (p_out_excl) else $error("both outputs on");

  property p_bz_idle;
    !bz_run |=> buzzer_out == $past(bz.buzzer_polarity);
  endproperty
  a_bz_idle: assert property (p_bz_idle) else $error("idle buzzer level wrong");

  property p_bz_slice;
    bz_run && !slice_on |=> buzzer_out == $past(bz.buzzer_polarity);
  endproperty
  a_bz_slice: assert property (p_bz_slice) else $error("buzzer active past duty");

  property p_remote_off;
    !rem.remote_enable |=> key_state_out == $past(rem.remote_out_invert);
  endproperty
  a_remote_off: assert property (p_remote_off) else $error("key state while disabled");

  property p_flag_set;
    rem.remote_enable && pressed_q |=> det_flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("detect flag missed");

  property p_debounce;
    $changed(pressed_q) |-> $past(deb_hit) && $past(key_low) == pressed_q;
  endproperty
  a_debounce: assert property (p_debounce) else $error("key change without debounce");

  property p_half_range;
    tick && range == ctl_pkg::RANGE_HALF |=> phase_q[0] == $past(phase_q[0]) + 17'($past(ctl_q[8]));
  endproperty
  a_half_range: assert property (p_half_range) else $error("halved phase step wrong");

  property p_sum;
    tone.tone_a_sel && tone.tone_b_sel |=> tone_sample == $past(wave[0]) + $past(b_scaled);
  endproperty
  a_sum: assert property (p_sum) else $error("dual tone not summed");

  c_write:  cover property (wr_evt);
  c_read:   cover property (rd_evt);
  c_flag:   cover property ($rose(det_flag_q));
  c_buzzer: cover property (bz_run ##1 $changed(buzzer_out));
endmodule : tone_ring_buzzer_remote_ctl
`default_nettype wire

// file: shared/ctl_pkg.sv
package ctl_pkg;
  localparam logic [3:0] IDX_UPLINK = 4'h3;
  localparam logic [3:0] IDX_PATH   = 4'h4;
  localparam logic [3:0] IDX_TXGAIN = 4'h5;
  localparam logic [3:0] IDX_RXGAIN = 4'h6;
  localparam logic [3:0] IDX_TONE   = 4'h7;
  localparam logic [3:0] IDX_FREQ_A = 4'h8;
  localparam logic [3:0] IDX_FREQ_B = 4'h9;
  localparam logic [3:0] IDX_REMOTE = 4'ha;
  localparam logic [3:0] IDX_BUZZER = 4'hb;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int         CMD_READ_BIT = 7;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] FRAME_LAST   = 5'h0f;
  localparam logic [4:0] DATA_FIRST   = 5'h08;
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [1:0] RANGE_STD    = 2'h0;
  localparam logic [1:0] RANGE_HALF   = 2'h1;
  localparam logic [1:0] RANGE_DOUBLE = 2'h2;
  localparam int SYS_CLK_PERIOD_NS = 8;
  localparam int DEBOUNCE_TIME_US  = 50000;
  localparam int DEBOUNCE_CYCLES   = DEBOUNCE_TIME_US * 1000 / SYS_CLK_PERIOD_NS;
  // 125 MHz * 64 / 15625 gives the 512 kHz phase tick
  localparam logic [13:0] TICK_STEP = 14'h0040;
  localparam logic [13:0] TICK_MOD  = 14'h3d09;
  localparam int          PHASE_W   = 17;
  localparam logic signed [7:0]  WAVE_PEAK    = 8'sh40;
  localparam logic signed [13:0] TONE_B_SCALE = 14'sh0033;
  localparam logic [6:0] SINE_QTR [16] = '{
    7'h00, 7'h06, 7'h0c, 7'h13, 7'h19, 7'h1e, 7'h24, 7'h29,
    7'h2d, 7'h31, 7'h35, 7'h38, 7'h3b, 7'h3d, 7'h3f, 7'h40};

  typedef enum logic [1:0] {TX_MUTE, TX_MIC_A, TX_MIC_B, TX_MIC_C} tx_input_type;

  typedef struct packed {
    logic tx_input_sel_hi;
    logic tx_input_sel_lo;
    logic sidetone_en;
    logic earpiece_out_sel;
    logic extra_out_sel;
    logic tone_route_sel;
    logic rx_hpf_sel;
    logic rx_speech_route;
  } path_type;

  typedef struct packed {
    logic [3:0] tone_atten;
    logic       tone_a_sel;
    logic       tone_b_sel;
    logic       sine_square_sel;
    logic       tone_to_uplink;
  } tone_type;

  typedef struct packed {
    logic remote_enable;
    logic remote_latch_mode;
    logic remote_out_invert;
    logic remote_detect_flag;
    logic preamp_gain_sel;
    logic mic_bias_on;
    logic range_double_sel;
    logic range_half_sel;
  } remote_type;

  typedef struct packed {
    logic       buzzer_enable;
    logic       buzzer_polarity;
    logic [5:0] duty;
  } buzzer_type;

  typedef struct packed {
    tx_input_type tx_input;
    logic [3:0]   tx_gain;
    logic         sidetone_on;
    logic [3:0]   sidetone_atten;
    logic         earpiece_on;
    logic         extra_on;
    logic         tone_to_extra;
    logic         speech_to_extra;
    logic         rx_hpf_sel;
    logic [3:0]   earpiece_gain;
    logic [3:0]   extra_gain;
    logic [3:0]   tone_atten;
    logic         tone_to_uplink;
    logic         preamp_0db;
    logic         mic_bias_on;
  } analog_type;
endpackage : ctl_pkg

// file: verif/serial_host.sv
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  output logic      cclk,
  output logic      cs_b,
  output logic      ci,
  input  wire logic co,
  input  wire logic co_oe
);
  logic [7:0] rd_q;
  int         oe_bad;
  event       rd_done;

  initial begin
    cclk   = 1'b0;
    cs_b   = 1'b1;
    ci     = 1'b0;
    oe_bad = 0;
    rd_q   = 8'h00;
  end

  // link clock runs only inside a frame; long high phase after the command byte
  task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input int nbits);
    logic [15:0] word;
    word = {cmd, dat};
    cs_b = 1'b0;
    #32;
    for (int i = 0; i < nbits; i++) begin
      ci = word[15-i];
      #32;
      cclk = 1'b1;
      if (i > 7) begin
        rd_q[15-i] = co;
        if (cmd[7] && co_oe !== 1'b1) oe_bad++;
      end
      #((i == 7) ? 64 : 32);
      cclk = 1'b0;
    end
    #32;
    ci   = ~ci;
    cs_b = 1'b1;
    #64;
    if (cmd[7] && nbits == 16) ->rd_done;
  endtask : frame
endmodule : serial_host
`default_nettype wire

// file: verif/tone_ring_buzzer_remote_ctl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tone_ring_buzzer_remote_ctl_tb;
  typedef struct {string what; logic [7:0] val;} note_type;
  logic                sys_clk, rst_b, cclk, cs_b, ci, co, co_oe;
  logic                key_sense_in, power_down, key_state_out, buzzer_out, det_exp, last_bz;
  logic signed [7:0]   tone_sample;
  ctl_pkg::analog_type analog_ctl;
  logic [7:0]          uplink_override, v;
  logic [3:0]          idx;
  logic [7:0]          sh [16];
  logic [7:0]          route_tab [4] = '{8'h20, 8'h60, 8'ha4, 8'he1};
  logic [31:0]         seed = 32'h00000058;
  int                  failures, checks_done, cnt, edges;
  note_type            exp_q[$];
  note_type            note;

  serial_host host (.cclk(cclk), .cs_b(cs_b), .ci(ci), .co(co), .co_oe(co_oe));
  tone_ring_buzzer_remote_ctl #(.DEBOUNCE_CYCLES(16)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .cclk(cclk), .cs_b(cs_b), .ci(ci), .co(co), .co_oe(co_oe),
    .key_sense_in(key_sense_in), .power_down(power_down), .key_state_out(key_state_out),
    .buzzer_out(buzzer_out), .tone_sample(tone_sample), .analog_ctl(analog_ctl),
    .uplink_override(uplink_override));

  always #4 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic ctl_pkg::analog_type exp_analog();
    ctl_pkg::analog_type a;
    a.tx_input        = ctl_pkg::tx_input_type'(sh[4][7:6]);
    a.tx_gain         = sh[5][7:4];
    a.sidetone_on     = sh[4][5] && (sh[4][7:6] != 2'h0);
    a.sidetone_atten  = sh[5][3:0];
    a.earpiece_on     = sh[4][4];
    a.extra_on        = sh[4][3];
    a.tone_to_extra   = sh[4][2];
    a.rx_hpf_sel      = sh[4][1];
    a.speech_to_extra = sh[4][0];
    a.earpiece_gain   = sh[6][7:4];
    a.extra_gain      = sh[6][3:0];
    a.tone_atten      = sh[7][7:4];
    a.tone_to_uplink  = sh[7][0];
    a.preamp_0db      = sh[10][3];
    a.mic_bias_on     = sh[10][2];
    return a;
  endfunction : exp_analog

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic wait_lvl(ref logic s, input logic lv, input int bound, input string what);
    for (int k = 0; k < bound && s !== lv; k++) @(negedge sys_clk);
    check(what, 32'(lv), 32'(s));
    if (s !== lv) end_sim();
  endtask : wait_lvl

  // register write settles a few system clocks after the frame
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    host.frame({4'h0, i}, d, 16);
    if (i == 4'ha) det_exp = 1'b0;
    sh[i] = (i == 4'ha) ? (d & 8'hef) : d;
    repeat (8) @(negedge sys_clk);
  endtask : wr

  task automatic rd(input logic [3:0] i, input string what);
    logic [7:0] e;
    e = (i < 4'h4 || i > 4'hb) ? 8'h00 : sh[i];
    if (i == 4'ha) e[4] = det_exp;
    exp_q.push_back('{what, e});
    host.frame({4'h8, i}, 8'h00, 16);
  endtask : rd

  always @(host.rd_done) begin
    if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
    else begin
      note = exp_q.pop_front();
      check(note.what, 32'(note.val), 32'(host.rd_q));
    end
  end

  task automatic press(input logic lv);
    @(negedge sys_clk);
    key_sense_in = lv;
  endtask : press

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    key_sense_in = 1'b1;
    power_down = 1'b0;
    det_exp = 1'b0;
    failures = 0;
    checks_done = 0;
    for (int i = 0; i < 16; i++) sh[i] = 8'h00;
    repeat (5) @(negedge sys_clk);
    check("outputs in reset", 32'h0, 32'({co_oe, key_state_out, buzzer_out, uplink_override, tone_sample}));
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("analog after reset", 32'h0, 32'(analog_ctl));
    for (int i = 3; i < 12; i++) rd(4'(i), "reset value");
    rd(4'hf, "unmapped read");
    for (int n = 0; n < 14; n++) begin
      idx = 4'h4 + 4'(xs() % 8);
      v = 8'(xs());
      if (idx == 4'h4 && v[4]) v[3] = 1'b0;
      if (idx == 4'ha && v[1:0] == 2'h3) v[1:0] = 2'h0;
      wr(idx, v);
      rd(idx, "register readback");
      check("analog selects", 32'(exp_analog()), 32'(analog_ctl));
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, route_tab[i]);
      check("tx input and sidetone", 32'(exp_analog()), 32'(analog_ctl));
    end
    wr(4'h3, 8'h5a);
    check("uplink override", 32'h5a, 32'(uplink_override));
    rd(4'h3, "write only read");
    host.frame(8'h05, ~sh[5], 12);
    repeat (8) @(negedge sys_clk);
    rd(4'h5, "aborted write");
    wr(4'he, 8'h5a);
    rd(4'he, "unmapped write");
    wr(4'ha, 8'h80);
    press(1'b0);
    repeat (6) @(negedge sys_clk);
    press(1'b1);
    repeat (40) @(negedge sys_clk);
    check("short press ignored", 32'h0, 32'(key_state_out));
    rd(4'ha, "no detect on glitch");
    press(1'b0);
    wait_lvl(key_state_out, 1'b1, 200, "key pressed");
    det_exp = 1'b1;
    rd(4'ha, "detect flag set");
    press(1'b1);
    wait_lvl(key_state_out, 1'b0, 200, "transparent release");
    wr(4'ha, 8'h80);
    rd(4'ha, "detect flag cleared");
    wr(4'ha, 8'ha0);
    wait_lvl(key_state_out, 1'b1, 50, "inverted idle");
    wr(4'ha, 8'hc0);
    press(1'b0);
    wait_lvl(key_state_out, 1'b1, 200, "latched press");
    det_exp = 1'b1;
    press(1'b1);
    repeat (60) @(negedge sys_clk);
    check("latched hold", 32'h1, 32'(key_state_out));
    wr(4'ha, 8'hc0);
    wait_lvl(key_state_out, 1'b0, 50, "latch cleared");
    wr(4'ha, 8'h20);
    wait_lvl(key_state_out, 1'b1, 20, "disabled key output");
    wr(4'hb, 8'h40);
    check("buzzer idle polarity", 32'h1, 32'(buzzer_out));
    wr(4'ha, 8'h02);
    wr(4'h8, 8'hff);
    wr(4'h7, 8'h08);
    wr(4'hb, 8'he0);
    cnt = 0;
    edges = 0;
    last_bz = buzzer_out;
    for (int c = 0; c < 62746; c++) begin
      @(negedge sys_clk);
      if (buzzer_out === 1'b0) cnt++;
      if (buzzer_out === 1'b0 && last_bz === 1'b1) edges++;
      last_bz = buzzer_out;
    end
    check("buzzer low share", 32'h1, 32'(cnt > 14386 && cnt < 16986));
    check("buzzer pulses", 32'h1, 32'(edges >= 2 && edges <= 3));
    check("square tone level", 32'h1, 32'(tone_sample === ctl_pkg::WAVE_PEAK || tone_sample === -ctl_pkg::WAVE_PEAK));
    power_down = 1'b1;
    wait_lvl(buzzer_out, 1'b1, 20, "buzzer power down");
    wr(4'hb, 8'h00);
    check("buzzer disabled", 32'h0, 32'(buzzer_out));
    check("read notes left", 32'h0, 32'(exp_q.size()));
    check("co enable during read", 32'h0, 32'(host.oe_bad));
    end_sim();
  end
endmodule : tone_ring_buzzer_remote_ctl_tb
`default_nettype wire
